/* File: rtl/nbl_pkg.sv */
// shared constants and types of the nand boot loader
package nbl_pkg;
  localparam logic [1:0] BOOT_SEL_NAND = 2'h0;
  localparam logic [23:0] SIG_UPPER_STD = 24'hA1BCED;
  localparam logic [23:0] SIG_UPPER_COMPAT = 24'hA1ACED;
  localparam logic [7:0] SIG_SAFE = 8'h00;
  localparam logic [7:0] SIG_DMA = 8'h11;
  localparam logic [7:0] SIG_ICACHE = 8'h22;
  localparam logic [7:0] SIG_FAST_INTERFACE = 8'h33;
  localparam logic [7:0] SIG_DMA_ICACHE = 8'h44;
  localparam logic [7:0] SIG_ALL_OPTIONS = 8'h55;
  localparam logic [7:0] SIG_EEPROM_PARAMS = 8'hAA;
  localparam logic [31:0] EEPROM_REC_SIG = 32'hA1ACEDAA;
  localparam logic [15:0] BLK_FIRST = 16'h0001;
  localparam logic [15:0] BLK_LAST = 16'h0018;
  localparam logic [15:0] DESC_PAGE = 16'h0000;
  localparam logic [16:0] RAM_IMG_BASE = 17'h10020;
  localparam logic [16:0] RAM_IMG_END = 17'h1781F;
  localparam logic [16:0] RAM_DBG_ADDR = 17'h07FFC;
  localparam logic [16:0] RAM_WORD_STEP = 17'h00004;
  // descriptor word index = page byte offset / 4
  localparam logic [2:0] DESC_W_SIG = 3'h0;
  localparam logic [2:0] DESC_W_ENTRY = 3'h1;
  localparam logic [2:0] DESC_W_NPAGES = 3'h2;
  localparam logic [2:0] DESC_W_SBLK = 3'h3;
  localparam logic [2:0] DESC_W_SPAGE = 3'h4;
  // eeprom record word index = byte offset / 4; words 0 and 1 unused
  localparam int EE_W_SIG = 2;
  localparam int EE_W_PPB = 3;
  localparam int EE_W_ACYC = 4;
  localparam int EE_W_PSIZE = 5;
  localparam int EE_W_SPARE = 6;
  localparam int EE_W_BSHIFT = 7;
  localparam logic [15:0] ECC_UNIT_BYTES = 16'h0200;
  localparam int ECC_PER_UNIT_SHIFT = 5;
  localparam int UNIT_SHIFT = 9;
  localparam logic [15:0] ID4_PPB_BASE = 16'h0040;
  localparam logic [15:0] ID4_PAGE_BASE = 16'h0400;
  localparam int STRM_W = 34;
  typedef enum logic [3:0] {
    NBL_IDLE = 4'h0,
    NBL_GEOM = 4'h1,
    NBL_SRCH_REQ = 4'h2,
    NBL_DESC = 4'h3,
    NBL_CHECK = 4'h4,
    NBL_DBG_WR = 4'h5,
    NBL_COPY_REQ = 4'h6,
    NBL_COPY = 4'h7,
    NBL_DRAIN = 4'h8,
    NBL_DONE = 4'h9,
    NBL_HANDOVER = 4'hA
  } nbl_state_t;
endpackage

/* File: rtl/nbl_strm_if.sv */
// valid/ready word stream between the loader and its buffer
`timescale 1ns/100ps
`default_nettype none
interface nbl_strm_if #(parameter int W = 34);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* File: rtl/nbl_buf2.sv */
// two-entry buffer with registered ready toward the filling side
`timescale 1ns/100ps
`default_nettype none
module nbl_buf2 #(
  parameter int W = 34
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  nbl_strm_if.snk s_in,
  nbl_strm_if.src s_out
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  assign s_in.ready = rdy_r;
  assign s_out.valid = (cnt_r != 2'h0);
  assign s_out.data = mem_r[rp_r];

  always_comb begin
    push = s_in.valid && rdy_r;
    pop = (cnt_r != 2'h0) && s_out.ready;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = s_in.data;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
    // ready registered so the source never sees a combinational path
    rdy_nxt = (cnt_nxt != 2'h2);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      rdy_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end
endmodule // nbl_buf2
`default_nettype wire

/* File: rtl/nbl_loader.sv */
// nand boot loader: geometry, descriptor search and image copy
// How it works
// - run only for select 00 after spi failure
// - compat layout: 512 data plus 16 ecc units
// - standard layout: contiguous data then ecc area
// - first descriptor look: block 1, page 0
// - bad signature: next block, 24 blocks max
// - write found block number to last ram word
// - nothing found in 24 blocks: hand to mmc
// - enable signature-selected options before copying
// - image goes to ram from 0x10020 to 0x1781F
// - skip the 32-byte vector table
// - 4-bit ecc check and correct during image reads
// - other read failure: resume search after descriptor block
// - descriptor words at offsets 0,4,8,12,16
// - signature upper pattern depends on layout
// - low byte selects the boot option
// - eeprom-params signature keeps compat upper pattern
// - geometry from eeprom, onfi, table or id byte
// - eeprom record fields at offsets 8 to 28
// - first 8 eeprom bytes ignored
// - onfi device: use parameter page values
// - id byte 4 decodes block and page size
`timescale 1ns/100ps
`default_nettype none
module nbl_loader
  import nbl_pkg::*;
#(
  parameter logic [7:0] DEF_ADDR_CYCLES = 8'h04,
  parameter logic [7:0] DEF_BLOCK_SHIFT = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_boot_select_pins,
  input wire logic i_spi_boot_failed,
  input wire logic i_std_layout,
  input wire logic i_eeprom_ok,
  input wire logic [255:0] i_eeprom_rec,
  input wire logic i_onfi_ok,
  input wire logic [15:0] i_onfi_page_bytes,
  input wire logic [15:0] i_onfi_pages_per_block,
  input wire logic i_tbl_hit,
  input wire logic [15:0] i_tbl_page_bytes,
  input wire logic [15:0] i_tbl_pages_per_block,
  input wire logic [7:0] i_id4,
  input wire logic [31:0] i_nd_data,
  input wire logic i_nd_last,
  input wire logic i_nd_err,
  input wire logic i_nd_valid,
  input wire logic i_ram_ready,
  output logic o_nd_ready,
  output logic o_rd_req,
  output logic [15:0] o_rd_block,
  output logic [15:0] o_rd_page,
  output logic o_ecc_en,
  output logic [15:0] o_page_bytes,
  output logic [15:0] o_pages_per_block,
  output logic [15:0] o_ecc_bytes,
  output logic [3:0] o_ecc_units,
  output logic [7:0] o_addr_cycles,
  output logic [7:0] o_block_shift,
  output logic o_dma_en,
  output logic o_icache_en,
  output logic o_fast_if_en,
  output logic o_ram_we,
  output logic [16:0] o_ram_addr,
  output logic [31:0] o_ram_wdata,
  output logic [31:0] o_entry_addr,
  output logic o_done,
  output logic o_mmc_handover
);
  nbl_strm_if #(.W(STRM_W)) s_in ();
  nbl_strm_if #(.W(STRM_W)) s_out ();

  nbl_buf2 #(.W(STRM_W)) u_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .s_in(s_in),
    .s_out(s_out)
  );

  assign s_in.data = {i_nd_err, i_nd_last, i_nd_data};
  assign s_in.valid = i_nd_valid;
  assign o_nd_ready = s_in.ready;

  nbl_state_t st_r, st_nxt;
  logic [15:0] blk_r, blk_nxt;
  logic [15:0] cblk_r, cblk_nxt;
  logic [15:0] cpage_r, cpage_nxt;
  logic [15:0] left_r, left_nxt;
  logic [2:0] widx_r, widx_nxt;
  logic [31:0] sig_r, sig_nxt;
  logic [31:0] entry_r, entry_nxt;
  logic [15:0] npages_r, npages_nxt;
  logic [15:0] sblk_r, sblk_nxt;
  logic [15:0] spage_r, spage_nxt;
  logic desc_bad_r, desc_bad_nxt;
  logic [16:0] waddr_r, waddr_nxt;
  logic [15:0] pgb_r, pgb_nxt;
  logic [15:0] ppb_r, ppb_nxt;
  logic [15:0] eccb_r, eccb_nxt;
  logic [3:0] units_r, units_nxt;
  logic [7:0] acyc_r, acyc_nxt;
  logic [7:0] bsh_r, bsh_nxt;
  logic dma_r, dma_nxt, ic_r, ic_nxt, fast_r, fast_nxt;
  logic req_r, req_nxt, ecc_r, ecc_nxt;
  logic we_r, we_nxt;
  logic [16:0] ra_r, ra_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic done_r, done_nxt, mmc_r, mmc_nxt;
  logic slot_free;
  logic sig_ok;
  logic [31:0] w;
  logic w_last, w_err;

  always_comb begin
    slot_free = !we_r || i_ram_ready;
    w = s_out.data[31:0];
    w_last = s_out.data[32];
    w_err = s_out.data[33];
    // words only leave the buffer while a read is consumed
    s_out.ready = (st_r == NBL_DESC) || ((st_r == NBL_COPY) && slot_free) ||
                  ((st_r == NBL_DRAIN) && desc_bad_r);
    // signature check: upper pattern by layout (compat for eeprom params), low byte a known code
    sig_ok = 1'b0;
    unique case (sig_r[7:0])
      SIG_SAFE, SIG_DMA, SIG_ICACHE, SIG_FAST_INTERFACE, SIG_DMA_ICACHE,
      SIG_ALL_OPTIONS: begin
        sig_ok = (sig_r[31:8] ==
                  (i_std_layout ? SIG_UPPER_STD : SIG_UPPER_COMPAT));
      end
      SIG_EEPROM_PARAMS: begin
        sig_ok = (sig_r[31:8] == SIG_UPPER_COMPAT);
      end
      default: begin
        sig_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    blk_nxt = blk_r;
    cblk_nxt = cblk_r;
    cpage_nxt = cpage_r;
    left_nxt = left_r;
    widx_nxt = widx_r;
    sig_nxt = sig_r;
    entry_nxt = entry_r;
    npages_nxt = npages_r;
    sblk_nxt = sblk_r;
    spage_nxt = spage_r;
    desc_bad_nxt = desc_bad_r;
    waddr_nxt = waddr_r;
    pgb_nxt = pgb_r;
    ppb_nxt = ppb_r;
    eccb_nxt = eccb_r;
    units_nxt = units_r;
    acyc_nxt = acyc_r;
    bsh_nxt = bsh_r;
    dma_nxt = dma_r;
    ic_nxt = ic_r;
    fast_nxt = fast_r;
    req_nxt = 1'b0;
    ecc_nxt = ecc_r;
    we_nxt = we_r && !i_ram_ready;
    ra_nxt = ra_r;
    rd_nxt = rd_r;
    done_nxt = done_r;
    mmc_nxt = mmc_r;
    unique case (st_r)
      NBL_IDLE: begin
        if (i_boot_select_pins == BOOT_SEL_NAND && i_spi_boot_failed) begin
          st_nxt = NBL_GEOM;
        end
      end
      NBL_GEOM: begin
        acyc_nxt = DEF_ADDR_CYCLES;
        bsh_nxt = DEF_BLOCK_SHIFT;
        // eeprom words 0 and 1 may hold a mac address and are never read
        if (i_eeprom_ok &&
            i_eeprom_rec[EE_W_SIG*32 +: 32] == EEPROM_REC_SIG) begin
          ppb_nxt = i_eeprom_rec[EE_W_PPB*32 +: 16];
          acyc_nxt = i_eeprom_rec[EE_W_ACYC*32 +: 8];
          pgb_nxt = i_eeprom_rec[EE_W_PSIZE*32 +: 16];
          bsh_nxt = i_eeprom_rec[EE_W_BSHIFT*32 +: 8];
          eccb_nxt = i_eeprom_rec[EE_W_SPARE*32 +: 16];
        end else if (i_onfi_ok) begin
          pgb_nxt = i_onfi_page_bytes;
          ppb_nxt = i_onfi_pages_per_block;
        end else if (i_tbl_hit) begin
          pgb_nxt = i_tbl_page_bytes;
          ppb_nxt = i_tbl_pages_per_block;
        end else begin
          // block 64KB<<b[5:4], page 1KB<<b[1:0]
          pgb_nxt = ID4_PAGE_BASE << i_id4[1:0];
          ppb_nxt = (ID4_PPB_BASE << i_id4[5:4]) >> i_id4[1:0];
        end
        blk_nxt = BLK_FIRST;
        desc_bad_nxt = 1'b1;
        sig_nxt = '0;
        widx_nxt = 3'h0;
        st_nxt = NBL_SRCH_REQ;
      end
      NBL_SRCH_REQ: begin
        // without a valid eeprom record, ecc area is 16 bytes per 512 data bytes in both layouts
        if (!(i_eeprom_ok &&
              i_eeprom_rec[EE_W_SIG*32 +: 32] == EEPROM_REC_SIG)) begin
          eccb_nxt = pgb_r >> ECC_PER_UNIT_SHIFT;
        end
        units_nxt = i_std_layout ? 4'h1 :
                    4'((pgb_r >> UNIT_SHIFT) & 16'h000F);
        req_nxt = 1'b1;
        ra_nxt = ra_r;
        cblk_nxt = blk_r;
        cpage_nxt = DESC_PAGE;
        widx_nxt = 3'h0;
        desc_bad_nxt = 1'b0;
        ecc_nxt = 1'b0;
        st_nxt = NBL_DESC;
      end
      NBL_DESC: begin
        if (s_out.valid) begin
          if (w_err) begin
            desc_bad_nxt = 1'b1;
          end
          if (widx_r <= DESC_W_SPAGE) begin
            widx_nxt = widx_r + 3'h1;
          end
          unique case (widx_r)
            DESC_W_SIG: sig_nxt = w;
            DESC_W_ENTRY: entry_nxt = w;
            DESC_W_NPAGES: npages_nxt = w[15:0];
            DESC_W_SBLK: sblk_nxt = w[15:0];
            DESC_W_SPAGE: spage_nxt = w[15:0];
            default: begin
            end
          endcase
          if (w_last) begin
            st_nxt = NBL_CHECK;
          end
        end
      end
      NBL_CHECK: begin
        if (sig_ok && !desc_bad_r && npages_r != 16'h0000) begin
          st_nxt = NBL_DBG_WR;
        end else if (blk_r == BLK_LAST) begin
          st_nxt = NBL_HANDOVER;
        end else begin
          blk_nxt = blk_r + 16'h0001;
          st_nxt = NBL_SRCH_REQ;
        end
      end
      NBL_DBG_WR: begin
        if (slot_free) begin
          we_nxt = 1'b1;
          ra_nxt = RAM_DBG_ADDR;
          rd_nxt = {16'h0000, blk_r};
          unique case (sig_r[7:0])
            SIG_DMA: dma_nxt = 1'b1;
            SIG_ICACHE: ic_nxt = 1'b1;
            SIG_FAST_INTERFACE: fast_nxt = 1'b1;
            SIG_DMA_ICACHE: begin
              dma_nxt = 1'b1;
              ic_nxt = 1'b1;
            end
            SIG_ALL_OPTIONS: begin
              dma_nxt = 1'b1;
              ic_nxt = 1'b1;
              fast_nxt = 1'b1;
            end
            default: begin
            end
          endcase
          // options stand before the first image read is issued
          cblk_nxt = sblk_r;
          cpage_nxt = spage_r;
          left_nxt = npages_r;
          waddr_nxt = RAM_IMG_BASE;
          st_nxt = NBL_COPY_REQ;
        end
      end
      NBL_COPY_REQ: begin
        req_nxt = 1'b1;
        ecc_nxt = 1'b1;
        st_nxt = NBL_COPY;
      end
      NBL_COPY: begin
        if (s_out.valid && slot_free) begin
          // uncorrectable page or image past ram end abandons this copy
          if (w_err || waddr_r > RAM_IMG_END - 17'h00003) begin
            ecc_nxt = 1'b0;
            dma_nxt = 1'b0;
            ic_nxt = 1'b0;
            fast_nxt = 1'b0;
            if (blk_r == BLK_LAST) begin
              st_nxt = NBL_HANDOVER;
            end else begin
              blk_nxt = blk_r + 16'h0001;
              st_nxt = w_last ? NBL_SRCH_REQ : NBL_DRAIN;
              desc_bad_nxt = 1'b1;
            end
          end else begin
            we_nxt = 1'b1;
            ra_nxt = waddr_r;
            rd_nxt = w;
            waddr_nxt = waddr_r + RAM_WORD_STEP;
            if (w_last) begin
              left_nxt = left_r - 16'h0001;
              if (left_r == 16'h0001) begin
                ecc_nxt = 1'b0;
                desc_bad_nxt = 1'b0;
                st_nxt = NBL_DRAIN;
              end else begin
                st_nxt = NBL_COPY_REQ;
                if (cpage_r + 16'h0001 == ppb_r) begin
                  cpage_nxt = 16'h0000;
                  cblk_nxt = cblk_r + 16'h0001;
                end else begin
                  cpage_nxt = cpage_r + 16'h0001;
                end
              end
            end
          end
        end
      end
      NBL_DRAIN: begin
        // after a failure, the rest of the bad page is discarded here
        if (desc_bad_r) begin
          if (s_out.valid && w_last) begin
            st_nxt = NBL_SRCH_REQ;
          end
        end else if (!s_out.valid && slot_free && !we_r) begin
          done_nxt = 1'b1;
          st_nxt = NBL_DONE;
        end
      end
      NBL_DONE: begin
        done_nxt = 1'b1;
      end
      NBL_HANDOVER: begin
        mmc_nxt = 1'b1;
      end
      default: begin
        st_nxt = NBL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= NBL_IDLE;
      blk_r <= BLK_FIRST;
      cblk_r <= 16'h0000;
      cpage_r <= 16'h0000;
      left_r <= 16'h0000;
      widx_r <= 3'h0;
      sig_r <= 32'h00000000;
      entry_r <= 32'h00000000;
      npages_r <= 16'h0000;
      sblk_r <= 16'h0000;
      spage_r <= 16'h0000;
      desc_bad_r <= 1'b0;
      waddr_r <= RAM_IMG_BASE;
      pgb_r <= 16'h0000;
      ppb_r <= 16'h0000;
      eccb_r <= 16'h0000;
      units_r <= 4'h0;
      acyc_r <= 8'h00;
      bsh_r <= 8'h00;
      dma_r <= 1'b0;
      ic_r <= 1'b0;
      fast_r <= 1'b0;
      req_r <= 1'b0;
      ecc_r <= 1'b0;
      we_r <= 1'b0;
      ra_r <= 17'h00000;
      rd_r <= 32'h00000000;
      done_r <= 1'b0;
      mmc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      blk_r <= blk_nxt;
      cblk_r <= cblk_nxt;
      cpage_r <= cpage_nxt;
      left_r <= left_nxt;
      widx_r <= widx_nxt;
      sig_r <= sig_nxt;
      entry_r <= entry_nxt;
      npages_r <= npages_nxt;
      sblk_r <= sblk_nxt;
      spage_r <= spage_nxt;
      desc_bad_r <= desc_bad_nxt;
      waddr_r <= waddr_nxt;
      pgb_r <= pgb_nxt;
      ppb_r <= ppb_nxt;
      eccb_r <= eccb_nxt;
      units_r <= units_nxt;
      acyc_r <= acyc_nxt;
      bsh_r <= bsh_nxt;
      dma_r <= dma_nxt;
      ic_r <= ic_nxt;
      fast_r <= fast_nxt;
      req_r <= req_nxt;
      ecc_r <= ecc_nxt;
      we_r <= we_nxt;
      ra_r <= ra_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      mmc_r <= mmc_nxt;
    end
  end

  assign o_rd_req = req_r;
  assign o_rd_block = cblk_r;
  assign o_rd_page = cpage_r;
  assign o_ecc_en = ecc_r;
  assign o_page_bytes = pgb_r;
  assign o_pages_per_block = ppb_r;
  assign o_ecc_bytes = eccb_r;
  assign o_ecc_units = units_r;
  assign o_addr_cycles = acyc_r;
  assign o_block_shift = bsh_r;
  assign o_dma_en = dma_r;
  assign o_icache_en = ic_r;
  assign o_fast_if_en = fast_r;
  assign o_ram_we = we_r;
  assign o_ram_addr = ra_r;
  assign o_ram_wdata = rd_r;
  assign o_entry_addr = entry_r;
  assign o_done = done_r;
  assign o_mmc_handover = mmc_r;
endmodule // nbl_loader
`default_nettype wire

/* File: sim/nbl_loader_props.sv */
// concurrent checks on the nand boot loader ports
`timescale 1ns/100ps
`default_nettype none
module nbl_loader_props
  import nbl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_boot_select_pins,
  input wire logic i_spi_boot_failed,
  input wire logic i_ram_ready,
  input wire logic o_rd_req,
  input wire logic [15:0] o_rd_block,
  input wire logic [15:0] o_rd_page,
  input wire logic o_ecc_en,
  input wire logic o_ram_we,
  input wire logic [16:0] o_ram_addr,
  input wire logic [31:0] o_ram_wdata,
  input wire logic o_done,
  input wire logic o_mmc_handover
);
  logic desc_req;
  logic [15:0] last_blk_r;
  logic [15:0] last_blk_nxt;
  // descriptor reads never carry ecc, image reads always do
  assign desc_req = o_rd_req && !o_ecc_en && o_rd_page == DESC_PAGE;
  always_comb begin
    last_blk_nxt = desc_req ? o_rd_block : last_blk_r;
  end
  always_ff @(posedge i_clk) begin
    last_blk_r <= !i_rst_n ? 16'h0000 : last_blk_nxt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_START_COND: assert property (
    o_rd_req |-> i_boot_select_pins == BOOT_SEL_NAND && i_spi_boot_failed)
    else $error("page read outside nand boot condition");
  AST_FIRST_LOOK: assert property (
    o_rd_req && last_blk_r == 16'h0000 |->
    !o_ecc_en && o_rd_page == DESC_PAGE && o_rd_block == BLK_FIRST)
    else $error("first read is not block 1 page 0");
  AST_SEARCH_ORDER: assert property (
    desc_req && last_blk_r != 16'h0000 |->
    o_rd_block == last_blk_r + 16'h0001 && o_rd_block <= BLK_LAST)
    else $error("descriptor search skipped or passed block 24");
  AST_DBG_BLOCK: assert property (
    o_ram_we && o_ram_addr == RAM_DBG_ADDR |->
    o_ram_wdata == {16'h0000, last_blk_r} && last_blk_r != 16'h0000)
    else $error("debug word differs from matched block");
  AST_RAM_WINDOW: assert property (
    o_ram_we |-> o_ram_addr == RAM_DBG_ADDR ||
    (o_ram_addr >= RAM_IMG_BASE && o_ram_addr <= RAM_IMG_END))
    else $error("ram write outside image window");
  AST_RAM_HOLD: assert property (
    o_ram_we && !i_ram_ready |=>
    o_ram_we && $stable(o_ram_addr) && $stable(o_ram_wdata))
    else $error("stalled ram write changed");
  AST_ECC_ON: assert property (
    o_rd_req && o_rd_page != DESC_PAGE |-> o_ecc_en)
    else $error("image page read without ecc");
  AST_HANDOVER: assert property (
    $rose(o_mmc_handover) |-> last_blk_r == BLK_LAST && !o_done)
    else $error("handover before block 24 searched");
  AST_DONE_HOLD: assert property (
    o_done |=> o_done && !o_mmc_handover)
    else $error("done dropped or handover after done");
endmodule // nbl_loader_props
bind nbl_loader nbl_loader_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_boot_select_pins(i_boot_select_pins),
  .i_spi_boot_failed(i_spi_boot_failed), .i_ram_ready(i_ram_ready),
  .o_rd_req(o_rd_req), .o_rd_block(o_rd_block), .o_rd_page(o_rd_page),
  .o_ecc_en(o_ecc_en), .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr),
  .o_ram_wdata(o_ram_wdata), .o_done(o_done),
  .o_mmc_handover(o_mmc_handover));
`default_nettype wire

/* File: sim/nbl_nand_model.sv */
// behavioural nand page reader on chip select zero
`timescale 1ns/100ps
`default_nettype none
module nbl_nand_model
  import nbl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rd_req,
  input wire logic [15:0] i_rd_block,
  input wire logic [15:0] i_rd_page,
  input wire logic [15:0] i_page_bytes,
  input wire logic i_nd_ready,
  input wire logic i_std_layout,
  input wire logic [15:0] i_good_from,
  input wire logic [15:0] i_fail_block,
  input wire logic [7:0] i_opt,
  input wire logic [31:0] i_entry,
  output logic [31:0] o_nd_data,
  output logic o_nd_last,
  output logic o_nd_err,
  output logic o_nd_valid
);
  logic busy, show;
  logic [15:0] blk, pg, idx, nw;
  logic [31:0] junk;
  logic [23:0] up, bad_up;
  function automatic logic [31:0] word(input logic [15:0] w);
    if (pg != DESC_PAGE || w > 16'h0004)
      return {blk[7:0], pg[7:0], w} ^ 32'h5A000000;
    case (w)
      16'h0000: return blk < i_good_from ? (blk[0] ? {bad_up, SIG_DMA} :
        {up, 8'h77}) : {up, i_opt};
      16'h0001: return i_entry;
      16'h0002: return 32'h00000002;
      16'h0003: return {16'h0000, blk};
      default: return 32'h00000001;
    endcase
  endfunction
  // eeprom-params signature keeps compat pattern in both layouts
  assign up = (i_std_layout && i_opt != SIG_EEPROM_PARAMS) ?
    SIG_UPPER_STD : SIG_UPPER_COMPAT;
  assign bad_up = i_std_layout ? SIG_UPPER_COMPAT : SIG_UPPER_STD;
  // page data contiguous, ecc area kept inside the reader
  assign o_nd_valid = busy && show;
  assign o_nd_data = o_nd_valid ? word(idx) : junk;
  assign o_nd_last = o_nd_valid && idx == nw - 16'h0001;
  assign o_nd_err = o_nd_last && blk == i_fail_block && pg != DESC_PAGE;
  always @(posedge i_clk) begin
    junk <= $urandom;
    show <= (o_nd_valid && !i_nd_ready) || ($urandom % 4 != 0);
    if (!i_rst_n) begin
      busy <= 1'b0;
    end else if (i_rd_req) begin
      busy <= 1'b1;
      {blk, pg, idx, nw} <= {i_rd_block, i_rd_page, 16'h0000, i_page_bytes >> 2};
    end else if (o_nd_valid && i_nd_ready) begin
      idx <= idx + 16'h0001;
      busy <= !o_nd_last;
    end
  end
endmodule // nbl_nand_model
`default_nettype wire

/* File: sim/nbl_loader_bench.sv */
// self-checking bench of the nand boot loader with a nand page model
`timescale 1ns/100ps
`default_nettype none
module nbl_loader_bench;
  import nbl_pkg::*;
  logic clk, rst_n, spi, std, eok, ook, thit, nl, ne, nv, rr;
  logic ndr, req, dma, ic, fst, we, done, hand;
  logic [1:0] sel;
  logic [7:0] id4, opt, acy, bsh, acy_o, bsh_o;
  logic [15:0] opb, oppb, tpb, tppb, good, failb, rb, rp, pb_o, ppb_o, eb_o;
  logic [3:0] eu_o;
  logic [16:0] wa;
  logic [31:0] nd, wd, entry, ent_o;
  logic [255:0] erec;
  logic [31:0] mem [logic [16:0]];
  logic [15:0] dbg_q [$];
  int bad_count, compares, n_req;
  nbl_loader dut (.i_clk(clk), .i_rst_n(rst_n), .i_boot_select_pins(sel),
    .i_spi_boot_failed(spi), .i_std_layout(std), .i_eeprom_ok(eok),
    .i_eeprom_rec(erec), .i_onfi_ok(ook), .i_onfi_page_bytes(opb),
    .i_onfi_pages_per_block(oppb), .i_tbl_hit(thit), .i_tbl_page_bytes(tpb),
    .i_tbl_pages_per_block(tppb), .i_id4(id4), .i_nd_data(nd), .i_nd_last(nl),
    .i_nd_err(ne), .i_nd_valid(nv), .i_ram_ready(rr), .o_nd_ready(ndr),
    .o_rd_req(req), .o_rd_block(rb), .o_rd_page(rp), .o_ecc_en(),
    .o_page_bytes(pb_o), .o_pages_per_block(ppb_o), .o_ecc_bytes(eb_o),
    .o_ecc_units(eu_o), .o_addr_cycles(acy_o), .o_block_shift(bsh_o),
    .o_dma_en(dma), .o_icache_en(ic), .o_fast_if_en(fst), .o_ram_we(we),
    .o_ram_addr(wa), .o_ram_wdata(wd), .o_entry_addr(ent_o), .o_done(done),
    .o_mmc_handover(hand));
  nbl_nand_model nand_m (.i_clk(clk), .i_rst_n(rst_n), .i_rd_req(req),
    .i_rd_block(rb), .i_rd_page(rp), .i_page_bytes(pb_o), .i_nd_ready(ndr),
    .i_std_layout(std), .i_good_from(good), .i_fail_block(failb),
    .i_opt(opt), .i_entry(entry), .o_nd_data(nd), .o_nd_last(nl),
    .o_nd_err(ne), .o_nd_valid(nv));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ram stalls about a quarter of cycles to back the buffer up
  always @(posedge clk) begin
    if (we && rr) mem[wa] = wd;
    if (we && rr && wa == RAM_DBG_ADDR) dbg_q.push_back(wd[15:0]);
    if (req) n_req++;
    #1 rr = ($urandom % 4) != 0;
  end
  function automatic logic [31:0] exp_word(logic [15:0] b, p, w);
    return {b[7:0], p[7:0], w} ^ 32'h5A000000;
  endfunction
  function automatic logic [2:0] exp_opt(logic [7:0] op);
    case (op)
      SIG_DMA: return 3'h4;
      SIG_ICACHE: return 3'h2;
      SIG_FAST_INTERFACE: return 3'h1;
      SIG_DMA_ICACHE: return 3'h6;
      SIG_ALL_OPTIONS: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic run(input logic [1:0] s, input logic f,
    input logic [15:0] g, fb, input logic [7:0] op);
    int k, w, src;
    logic [15:0] pb, ppb, sp, fin;
    rst_n = 1'b0;
    {sel, spi, good, failb, opt, std, entry} = {s, f, g, fb, op, 1'($urandom), 32'($urandom)};
    src = $urandom % 4;
    {eok, ook, thit} = {src == 0, src <= 1, src <= 2};
    for (k = 0; k < 8; k++) erec[32*k+:32] = $urandom;
    {opb, tpb} = {16'h0200 << 2 * ($urandom % 2), 16'h0800 >> 2 * ($urandom % 2)};
    {oppb, tppb, sp} = {16'h0020 << ($urandom % 2), 16'h0040, 16'($urandom)};
    {acy, bsh} = {8'($urandom % 3 + 3), 8'($urandom % 4)};
    id4 = {2'h0, 2'($urandom), 3'h0, 1'($urandom)};
    erec[64+:192] = {24'h0, bsh, 16'h0, sp, 16'h0, tpb, 24'h0, acy, 16'h0,
      tppb, EEPROM_REC_SIG};
    {pb, ppb} = src == 1 ? {opb, oppb} : src != 3 ? {tpb, tppb} :
      {16'h0400 << id4[1:0], 16'((64 << id4[5:4]) >> id4[1:0])};
    repeat (4) @(posedge clk);
    mem.delete();
    dbg_q.delete();
    n_req = 0;
    #1 rst_n = 1'b1;
    if (!(s == BOOT_SEL_NAND && f)) begin
      repeat (60) @(posedge clk) #1;
      chk(n_req, 0);
      chk({done, hand}, 0);
      return;
    end
    for (k = 0; k < 200 && req !== 1'b1; k++) @(posedge clk) #1;
    chk({pb_o, ppb_o}, {pb, ppb});
    chk(eu_o, std ? 4'h1 : 4'(pb >> 9));
    chk(eb_o, src == 0 ? sp : std ? pb >> 5 : (pb >> 9) * 16);
    chk({acy_o, bsh_o}, src == 0 ? {acy, bsh} : 16'h0400);
    for (k = 0; k < 60000 && !(done === 1'b1 || hand === 1'b1); k++)
      @(posedge clk) #1;
    if (g > BLK_LAST) begin
      chk({done, hand}, 2'h1);
      chk(n_req, 24);
      return;
    end
    fin = fb == g ? g + 16'h0001 : g;
    chk({done, hand}, 2'h2);
    chk(dbg_q.size(), fin - g + 1);
    chk(dbg_q[0], g);
    chk(mem[RAM_DBG_ADDR], fin);
    chk(ent_o, entry);
    chk({dma, ic, fst}, exp_opt(op));
    w = pb >> 2;
    for (k = 0; k < 2 * w; k++)
      chk(mem[RAM_IMG_BASE + 17'(4 * k)], exp_word(fin, 16'(1 + k / w),
        16'(k % w)));
  endtask
  initial begin
    logic [7:0] ops [7];
    ops = '{SIG_SAFE, SIG_DMA, SIG_ICACHE, SIG_FAST_INTERFACE, SIG_DMA_ICACHE,
      SIG_ALL_OPTIONS, SIG_EEPROM_PARAMS};
    {rst_n, sel, spi, std, eok, ook, thit, rr, id4, erec} = '0;
    {opb, oppb, tpb, tppb, good, failb, opt, entry} = '0;
    {bad_count, compares, n_req} = '0;
    void'($urandom(32'hf9fa570f));
    run(2'h2, 1'b1, 16'h0001, 16'h0000, SIG_DMA);
    run(2'h0, 1'b0, 16'h0001, 16'h0000, SIG_DMA);
    // first pass: two bad blocks then a copy failure and retry
    for (int i = 0; i < 7; i++)
      run(2'h0, 1'b1, i == 0 ? 16'h0003 : 16'($urandom % 4 + 1),
        i == 0 ? 16'h0003 : 16'h0000, ops[i]);
    run(2'h0, 1'b1, 16'h0019, 16'h0000, SIG_SAFE);
    wrap_up();
  end
  initial begin
    #(40 * 95000);
    bad_count++;
    wrap_up();
  end
endmodule // nbl_loader_bench
`default_nettype wire
